//--- rtl/smew_pkg.sv
// Package of constants and types for the static memory external wait block.
`default_nettype none
package smew_pkg;
  localparam int        CS_NUM        = 4;
  localparam int        CNT_W         = 6;
  localparam logic [1:0] WAIT_DISABLED = 2'h0;
  localparam logic [1:0] WAIT_RSVD     = 2'h1;
  localparam logic [1:0] WAIT_FROZEN   = 2'h2;
  localparam logic [1:0] WAIT_READY    = 2'h3;
  localparam logic [1:0] WAIT_MODE_RST = 2'h0;
  localparam logic       STROBE_IDLE   = 1'b1;
  localparam logic [5:0] CNT_RST       = 6'h00;
  localparam int        SYNC_STAGES   = 2;

  typedef enum logic [1:0] {
    SMEW_IDLE,
    SMEW_SETUP,
    SMEW_PULSE,
    SMEW_HOLD
  } smew_phase_type;
endpackage
`default_nettype wire

//--- rtl/smew_sync.sv
// Two-stage synchroniser for the active-low external wait pin.
`default_nettype none
module smew_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = asyncIn;
    sync_d = meta_q;
  end

  // Resets to the inactive (high) level so a stalled pin at reset does not freeze.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign syncOut = sync_q;
endmodule
`default_nettype wire

//--- rtl/smew_access.sv
// Access sequencer of the static memory controller with external wait handling.
//
// Contract
// - Wait pin stretches accesses only when the chip select mode is frozen or ready.
// - Disabled wait mode ignores the wait pin entirely.
// - Wait stalls relative to the controlling strobe chosen by read or write mode.
// - Synchronised wait is sampled only during the strobe pulse phase.
// - Wait asserted outside the sampling window has no effect.
// - Wait is active low and synchronised before use.
// - Frozen mode stops all counters and holds every control output.
// - On release, the access resumes from the exact phase and count.
`default_nettype none
module smew_access #(
  parameter int CS_NUM = smew_pkg::CS_NUM,
  parameter int CNT_W  = smew_pkg::CNT_W
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      extWaitN,
  input  wire logic [2*CS_NUM-1:0]       waitModeSel,
  input  wire logic [CS_NUM-1:0]         readNcsCtrl,
  input  wire logic [CS_NUM-1:0]         writeNcsCtrl,
  input  wire logic                      accReq,
  input  wire logic                      accWrite,
  input  wire logic [$clog2(CS_NUM)-1:0] accCs,
  input  wire logic [CNT_W-1:0]          setupCycles,
  input  wire logic [CNT_W-1:0]          pulseCycles,
  input  wire logic [CNT_W-1:0]          holdCycles,
  output logic                           accBusy,
  output logic                           accDone,
  output logic                           accStalled,
  output logic [CS_NUM-1:0]              chipSelN,
  output logic                           readStrobeN,
  output logic                           writeStrobeN
);

  ////////////////////////////////////////////////////////////////////////////
  // Wait input conditioning.

  logic waitSyncN;

  smew_sync u_sync (
    .clk    (clk),
    .rst    (rst),
    .asyncIn(extWaitN),
    .syncOut(waitSyncN)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state.

  smew_pkg::smew_phase_type phase_q;
  smew_pkg::smew_phase_type phase_d;
  logic [CNT_W-1:0]          cnt_q;
  logic [CNT_W-1:0]          cnt_d;
  logic                      write_q;
  logic                      write_d;
  logic [$clog2(CS_NUM)-1:0] cs_q;
  logic [$clog2(CS_NUM)-1:0] cs_d;
  logic [CNT_W-1:0]          pulse_q;
  logic [CNT_W-1:0]          pulse_d;
  logic [CNT_W-1:0]          hold_q;
  logic [CNT_W-1:0]          hold_d;
  logic [1:0]                mode_q;
  logic [1:0]                mode_d;
  logic                      ncsCtrl_q;
  logic                      ncsCtrl_d;
  logic                      done_q;
  logic                      done_d;
  logic                      stall_q;
  logic                      stall_d;
  logic [CS_NUM-1:0]         csN_q;
  logic [CS_NUM-1:0]         csN_d;
  logic                      rdN_q;
  logic                      rdN_d;
  logic                      wrN_q;
  logic                      wrN_d;
  logic                      waitOn;
  logic                      freeze;
  logic [1:0]                reqMode;

  always_comb begin
    reqMode = waitModeSel[2*accCs +: 2];
  end

  // Only the frozen and ready encodings honour the pin; ready is treated like
  // frozen here because its distinct behaviour is not defined for this block.
  always_comb begin
    waitOn = (mode_q == smew_pkg::WAIT_FROZEN) || (mode_q == smew_pkg::WAIT_READY);
    // The freeze is evaluated only in the pulse phase of the controlling strobe;
    // with NCS control the chip select pulse is the same phase window.
    freeze = waitOn && (phase_q == smew_pkg::SMEW_PULSE) && !waitSyncN;
  end

  always_comb begin
    phase_d   = phase_q;
    cnt_d     = cnt_q;
    write_d   = write_q;
    cs_d      = cs_q;
    pulse_d   = pulse_q;
    hold_d    = hold_q;
    mode_d    = mode_q;
    ncsCtrl_d = ncsCtrl_q;
    done_d    = 1'b0;
    stall_d   = freeze;
    csN_d     = csN_q;
    rdN_d     = rdN_q;
    wrN_d     = wrN_q;
    if (freeze) begin
      // Everything holds; there is deliberately no timeout counter.
      phase_d = phase_q;
    end else begin
      case (phase_q)
        smew_pkg::SMEW_IDLE: begin
          if (accReq) begin
            write_d   = accWrite;
            cs_d      = accCs;
            pulse_d   = pulseCycles;
            hold_d    = holdCycles;
            mode_d    = reqMode;
            ncsCtrl_d = accWrite ? writeNcsCtrl[accCs] : readNcsCtrl[accCs];
            cnt_d     = setupCycles;
            phase_d   = smew_pkg::SMEW_SETUP;
            csN_d     = {CS_NUM{1'b1}};
            if (ncsCtrl_d == 1'b0) begin
              csN_d[accCs] = 1'b0;
            end
          end
        end
        smew_pkg::SMEW_SETUP: begin
          if (cnt_q == '0) begin
            phase_d      = smew_pkg::SMEW_PULSE;
            cnt_d        = pulse_q;
            csN_d[cs_q]  = 1'b0;
            rdN_d        = write_q;
            wrN_d        = !write_q;
          end else begin
            cnt_d = cnt_q - CNT_W'(1);
          end
        end
        smew_pkg::SMEW_PULSE: begin
          // Resumes here with the counter value kept through the stall.
          if (cnt_q == '0) begin
            phase_d = smew_pkg::SMEW_HOLD;
            cnt_d   = hold_q;
            rdN_d   = smew_pkg::STROBE_IDLE;
            wrN_d   = smew_pkg::STROBE_IDLE;
            if (ncsCtrl_q) begin
              csN_d = {CS_NUM{1'b1}};
            end
          end else begin
            cnt_d = cnt_q - CNT_W'(1);
          end
        end
        smew_pkg::SMEW_HOLD: begin
          if (cnt_q == '0) begin
            phase_d = smew_pkg::SMEW_IDLE;
            csN_d   = {CS_NUM{1'b1}};
            done_d  = 1'b1;
          end else begin
            cnt_d = cnt_q - CNT_W'(1);
          end
        end
        default: begin
          phase_d = smew_pkg::SMEW_IDLE;
          csN_d   = {CS_NUM{1'b1}};
          rdN_d   = smew_pkg::STROBE_IDLE;
          wrN_d   = smew_pkg::STROBE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q   <= smew_pkg::SMEW_IDLE;
      cnt_q     <= smew_pkg::CNT_RST;
      write_q   <= 1'b0;
      cs_q      <= '0;
      pulse_q   <= smew_pkg::CNT_RST;
      hold_q    <= smew_pkg::CNT_RST;
      mode_q    <= smew_pkg::WAIT_MODE_RST;
      ncsCtrl_q <= 1'b0;
      done_q    <= 1'b0;
      stall_q   <= 1'b0;
      csN_q     <= {CS_NUM{1'b1}};
      rdN_q     <= smew_pkg::STROBE_IDLE;
      wrN_q     <= smew_pkg::STROBE_IDLE;
    end else begin
      phase_q   <= phase_d;
      cnt_q     <= cnt_d;
      write_q   <= write_d;
      cs_q      <= cs_d;
      pulse_q   <= pulse_d;
      hold_q    <= hold_d;
      mode_q    <= mode_d;
      ncsCtrl_q <= ncsCtrl_d;
      done_q    <= done_d;
      stall_q   <= stall_d;
      csN_q     <= csN_d;
      rdN_q     <= rdN_d;
      wrN_q     <= wrN_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops.

  logic busy_q;
  logic busy_d;

  always_comb begin
    busy_d = (phase_d != smew_pkg::SMEW_IDLE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

  assign accBusy      = busy_q;
  assign accDone      = done_q;
  assign accStalled   = stall_q;
  assign chipSelN     = csN_q;
  assign readStrobeN  = rdN_q;
  assign writeStrobeN = wrN_q;

endmodule
`default_nettype wire

//--- dv/smew_access_monitor.sv
// Port checker for the access sequencer.
`default_nettype none
module smew_access_monitor #(
  parameter int CS_NUM = smew_pkg::CS_NUM
) (
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic                      extWaitN,
  input wire logic [2*CS_NUM-1:0]       waitModeSel,
  input wire logic [$clog2(CS_NUM)-1:0] accCs,
  input wire logic                      accBusy,
  input wire logic                      accDone,
  input wire logic                      accStalled,
  input wire logic [CS_NUM-1:0]         chipSelN,
  input wire logic                      readStrobeN,
  input wire logic                      writeStrobeN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_quiet;
    extWaitN [*4];
  endsequence
  sequence s_ends;
    accDone ##1 !accDone;
  endsequence
  chk_stall_hold: assert property (accStalled |-> accBusy && $stable(chipSelN)
    && $stable(readStrobeN) && $stable(writeStrobeN)) else $error("outputs moved while stalled");
  chk_wait_mode: assert property (accStalled |-> waitModeSel[{accCs, 1'b1}])
    else $error("stall with wait disabled");
  chk_quiet_run: assert property (s_quiet |=> !accStalled) else $error("stall without wait");
  chk_stall_win: assert property (accStalled |-> !(readStrobeN && writeStrobeN))
    else $error("stall outside pulse");
  chk_done_once: assert property (accDone |-> s_ends) else $error("done too long");
  chk_done_idle: assert property (accDone |-> !accBusy && (&chipSelN)
    && readStrobeN && writeStrobeN) else $error("outputs active at done");
  chk_release_go: assert property ($fell(accStalled) |-> accBusy) else $error("access lost");
  chk_strobe_excl: assert property (!readStrobeN |-> writeStrobeN) else $error("both strobes");
  chk_cs_pulse: assert property (!(readStrobeN && writeStrobeN) |-> !(&chipSelN))
    else $error("strobe without chip select");
endmodule
bind smew_access smew_access_monitor #(.CS_NUM(CS_NUM)) u_mon (.clk, .rst, .extWaitN, .waitModeSel,
  .accCs, .accBusy, .accDone, .accStalled, .chipSelN, .readStrobeN, .writeStrobeN);
`default_nettype wire

//--- dv/smew_wait_dev.sv
// Behavioural external device that stretches accesses with the wait pin.
`default_nettype none
module smew_wait_dev (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       readStrobeN,
  input  wire logic       writeStrobeN,
  input  wire logic [7:0] stallLen,
  input  wire logic       stray,
  output logic            extWaitN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       low_q;
  logic [7:0] cnt_q;
  // The wait answers a request, so it is launched only when a strobe falls.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_q <= 1'b0;
      cnt_q <= 8'h00;
    end else begin
      low_q <= !(readStrobeN && writeStrobeN);
      if (!(readStrobeN && writeStrobeN) && !low_q)
        cnt_q <= stallLen;
      else if (cnt_q != 8'h00)
        cnt_q <= cnt_q - 8'h01;
    end
  end
  // The pin is pulled up, so it reads high whenever nobody stalls.
  assign extWaitN = !(stray || cnt_q != 8'h00);
endmodule
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the access sequencer.
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst, extWaitN, accReq, accWrite, stray;
  logic       accBusy, accDone, accStalled, readStrobeN, writeStrobeN;
  logic [7:0] waitModeSel, stallLen;
  logic [3:0] readNcsCtrl, writeNcsCtrl, chipSelN;
  logic [1:0] accCs;
  logic [5:0] setupCycles, pulseCycles, holdCycles;
  int         fail_count, tests_run;
  smew_access DUT (.clk, .rst, .extWaitN, .waitModeSel, .readNcsCtrl, .writeNcsCtrl, .accReq,
    .accWrite, .accCs, .setupCycles, .pulseCycles, .holdCycles, .accBusy, .accDone, .accStalled,
    .chipSelN, .readStrobeN, .writeStrobeN);
  smew_wait_dev WDEV (.clk, .rst, .readStrobeN, .writeStrobeN, .stallLen, .stray, .extWaitN);
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Access of setup 2, pulse 6, hold 1: 13 cycles to done plus the stalled ones.
  task automatic run(input logic [1:0] cs, input logic wr, input logic [7:0] st, input int ex);
    int   n, ns, nl, nc, nb, nx;
    logic ncs;
    ncs = wr ? writeNcsCtrl[cs] : readNcsCtrl[cs];
    n = 0;
    ns = 0;
    nl = 0;
    nc = 0;
    nb = 0;
    nx = 0;
    @(negedge clk);
    accCs = cs;
    accWrite = wr;
    stallLen = st;
    accReq = 1'b1;
    do begin
      @(negedge clk);
      accReq = 1'b0;
      n++;
      ns += int'(accStalled === 1'b1);
      nl += int'(wr ? writeStrobeN === 1'b0 : readStrobeN === 1'b0);
      nc += int'(chipSelN[cs] === 1'b0);
      nb += int'(accBusy === 1'b1);
      nx += int'((chipSelN | (4'h1 << cs)) !== 4'hF);
    end while (accDone !== 1'b1 && n < 200);
    if (accDone !== 1'b1) begin
      fail_count++;
      end_sim;
    end
    `CHK(n, 13 + ex)
    `CHK(ns, ex)
    `CHK(nl, 7 + ex)
    `CHK(nb, 12 + ex)
    // A chip select that controls the access itself is low only through the pulse phase.
    `CHK(nc, (ncs ? 7 : 12) + ex)
    `CHK(nx, 0)
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      waitModeSel = 8'h00;
      waitModeSel[2*m+:2] = 2'(m);
      run(2'(m), m[0], 8'h03, m > 1 ? 3 : 0);
    end
  endtask
  task automatic t_write;
    waitModeSel = 8'hAA;
    run(2'h2, 1'b1, 8'h05, 5);
  endtask
  // The stray wait reaches the synchroniser output during setup, outside the pulse window.
  task automatic t_stray;
    @(negedge clk);
    stray = 1'b1;
    fork
      begin
        repeat (2) @(negedge clk);
        stray = 1'b0;
      end
      run(2'h1, 1'b0, 8'h00, 0);
    join
  endtask
  // A reset in the middle of a frozen access must drop every output back to idle.
  task automatic t_reset;
    @(negedge clk);
    accCs = 2'h3;
    accWrite = 1'b1;
    stallLen = 8'h28;
    accReq = 1'b1;
    @(negedge clk);
    accReq = 1'b0;
    repeat (8) @(negedge clk);
    `CHK(accStalled, 1'b1)
    rst = 1'b1;
    @(negedge clk);
    `CHK({accBusy, accStalled, accDone, chipSelN, readStrobeN, writeStrobeN}, 9'h03F)
    rst = 1'b0;
    @(negedge clk);
    `CHK({accBusy, accStalled, accDone, chipSelN, readStrobeN, writeStrobeN}, 9'h03F)
  endtask
  task automatic t_long;
    waitModeSel = 8'hFF;
    writeNcsCtrl = 4'h8;
    run(2'h3, 1'b1, 8'h28, 40);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {accReq, accWrite, stray, stallLen, accCs, waitModeSel} = '0;
    readNcsCtrl = 4'h0;
    writeNcsCtrl = 4'h0;
    setupCycles = 6'h02;
    pulseCycles = 6'h06;
    holdCycles = 6'h01;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_modes;
    t_write;
    t_stray;
    t_reset;
    t_long;
    end_sim;
  end
endmodule
`default_nettype wire
